// ===== omsc_top.sv
module omsc_top
   import omsc_pkg::*;
#(
   parameter int unsigned P_SETTLE_0 = SETTLE_STATES_0,
   parameter int unsigned P_SETTLE_1 = SETTLE_STATES_1,
   parameter int unsigned P_SETTLE_2 = SETTLE_STATES_2,
   parameter int unsigned P_SETTLE_3 = SETTLE_STATES_3,
   parameter int unsigned P_SETTLE_4 = SETTLE_STATES_4,
   parameter int unsigned P_SETTLE_5 = SETTLE_STATES_5,
   parameter int unsigned P_SETTLE_6 = SETTLE_STATES_6,
   parameter int          N_AREAS    = 8
)
(
   input  wire logic              i_mclk,          // system clock
   input  wire logic              i_sys_rst,       // sync reset, high
   // register port
   input  wire logic [ADDR_W-1:0] i_addr,          // low address bits
   input  wire logic [DATA_W-1:0] i_wdata,         // write data
   input  wire logic              i_wr,            // write strobe
   input  wire logic              i_rd,            // read strobe
   output logic      [DATA_W-1:0] o_rdata,         // read data, next cycle
   // strapped pins and bus controller
   input  wire logic              i_mode_pin_2,    // mode pin 2
   input  wire logic              i_mode_pin_1,    // mode pin 1
   input  wire logic              i_mode_pin_0,    // mode pin 0
   input  wire logic [N_AREAS-1:0] i_area_width_control, // 1 = 16-bit
   output logic                   o_mode_valid,    // legal mode strapped
   output logic                   o_expanded,      // external bus in use
   output logic                   o_init_bus_16,   // initial width 16
   output logic                   o_bus_16,        // current width 16
   output logic                   o_rom_enable,    // internal rom on
   output logic [1:0]             o_space,         // space size code
   output logic                   o_ports_free,    // ports all general io
   // internal ram routing
   input  wire logic              i_ram_range_hit, // access in ram range
   output logic                   o_ram_internal,  // serve from ram
   output logic                   o_ram_external,  // route to bus
   // core events
   input  wire logic              i_sleep_exec,    // sleep executed
   input  wire logic              i_wake_irq,      // any interrupt
   input  wire logic              i_ext_irq,       // external interrupt
   input  wire logic              i_exc_entry,     // exception entry
   input  wire logic              i_nmi,           // nmi pin level
   output logic                   o_nmi_request,   // nmi edge pulse
   output logic                   o_set_mask_flag, // set mask flag pulse
   output logic                   o_set_user_flag, // set second flag pulse
   output logic                   o_user_flag_mode,// flag is user bit
   output logic                   o_sleep_entry,   // enter sleep pulse
   output logic                   o_standby_entry, // enter standby pulse
   output logic                   o_resume,        // back to run pulse
   output logic                   o_in_standby,    // standby or settling
   output logic                   o_addr_hiz,      // address bus off
   output logic                   o_ctrl_hiz,      // bus control off
   output logic                   o_addr_hold,     // address bus kept
   output logic                   o_ctrl_high      // bus control forced 1
);

   // ************************************************************
   // state of the block
   // ************************************************************

   typedef struct packed {
      logic [7:0]  sysctl;
      logic [7:0]  rdata;
      omsc_state_e st;
      logic        nmi_prev;
      logic        nmi_req;
      logic        mask_p;
      logic        user_p;
      logic        sleep_p;
      logic        stby_p;
      logic        resume_p;
      logic        tmr_start;
   } omsc_top_s;

   omsc_top_s top_ff;
   omsc_top_s nxt_top;

   logic [2:0]              mode;
   logic                    dec_valid;
   logic                    dec_expanded;
   logic                    dec_single;
   logic                    dec_init16;
   logic                    dec_rom;
   logic [1:0]              dec_space;
   logic [SETTLE_CNT_W-1:0] settle_cnt;
   logic                    tmr_done;
   logic                    nmi_rise;
   logic                    nmi_fall;

   // settle code to wait length; the illegal code takes the longest
   function automatic logic [SETTLE_CNT_W-1:0] settle_len(
      input logic [2:0] code
   );
      int unsigned n;
      unique case (code)
         3'h0:    n = P_SETTLE_0;
         3'h1:    n = P_SETTLE_1;
         3'h2:    n = P_SETTLE_2;
         3'h3:    n = P_SETTLE_3;
         3'h4:    n = P_SETTLE_4;
         3'h5:    n = P_SETTLE_5;
         3'h6:    n = P_SETTLE_6;
         3'h7:    n = P_SETTLE_5;
      endcase
      return SETTLE_CNT_W'(n * CYC_PER_STATE);
   endfunction : settle_len

   // ************************************************************
   // mode decode and settle timer
   // ************************************************************

   // pins assumed held constant by the board
   assign mode = {i_mode_pin_2, i_mode_pin_1, i_mode_pin_0};

   omsc_mode_decode u_dec (
      .i_mode        (mode),
      .o_valid       (dec_valid),
      .o_expanded    (dec_expanded),
      .o_single_chip (dec_single),
      .o_init_bus_16 (dec_init16),
      .o_rom_enable  (dec_rom),
      .o_space       (dec_space)
   );

   // wait length from the live settle field
   assign settle_cnt = settle_len(top_ff.sysctl[SETTLE_MSB:SETTLE_LSB]);

   omsc_settle_timer #(
      .CNT_W (SETTLE_CNT_W)
   ) u_tmr (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_start   (top_ff.tmr_start),
      .i_count   (settle_cnt),
      .o_busy    (),
      .o_done    (tmr_done)
   );

   // nmi edges of the sampled pin
   assign nmi_rise = i_nmi && !top_ff.nmi_prev;
   assign nmi_fall = !i_nmi && top_ff.nmi_prev;

   // ************************************************************
   // next state
   // ************************************************************

   // register port, nmi, exception flags and power sequencing
   always_comb begin
      nxt_top           = top_ff;
      nxt_top.rdata     = '0;
      nxt_top.mask_p    = 1'b0;
      nxt_top.user_p    = 1'b0;
      nxt_top.sleep_p   = 1'b0;
      nxt_top.stby_p    = 1'b0;
      nxt_top.resume_p  = 1'b0;
      nxt_top.tmr_start = 1'b0;
      nxt_top.nmi_prev  = i_nmi;

      // writes; the status register ignores them
      if (i_wr && (i_addr == SYS_CONTROL_ADDR)) begin
         nxt_top.sysctl = i_wdata;
      end

      // reads; unmapped addresses return zero
      if (i_rd) begin
         if (i_addr == MODE_STATUS_ADDR) begin
            nxt_top.rdata = MODE_STATUS_FIXED;
            nxt_top.rdata[MODE_BITS_LSB +: MODE_BITS_W] = mode;
         end else if (i_addr == SYS_CONTROL_ADDR) begin
            nxt_top.rdata = top_ff.sysctl;
         end
      end

      // nmi request on the selected edge
      nxt_top.nmi_req = top_ff.sysctl[NMI_EDGE_BIT] ? nmi_rise
                                                    : nmi_fall;

      // exception entry sets mask; second flag too unless user bit
      if (i_exc_entry) begin
         nxt_top.mask_p = 1'b1;
         nxt_top.user_p = !top_ff.sysctl[USER_FLAG_EN_BIT];
      end

      // power sequencing; register contents stay across standby
      unique case (top_ff.st)
         ST_RUN: begin
            if (i_sleep_exec) begin
               if (top_ff.sysctl[STANDBY_SEL_BIT]) begin
                  nxt_top.st     = ST_STANDBY;
                  nxt_top.stby_p = 1'b1;
               end else begin
                  nxt_top.st      = ST_SLEEP;
                  nxt_top.sleep_p = 1'b1;
               end
            end
         end
         ST_SLEEP: begin
            if (i_wake_irq) begin
               nxt_top.st       = ST_RUN;
               nxt_top.resume_p = 1'b1;
            end
         end
         ST_STANDBY: begin
            if (i_ext_irq) begin
               nxt_top.st        = ST_SETTLE;
               nxt_top.tmr_start = 1'b1;
            end
         end
         ST_SETTLE: begin
            // standby select is left as written
            if (tmr_done) begin
               nxt_top.st       = ST_RUN;
               nxt_top.resume_p = 1'b1;
            end
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************

   // reset restores the control register, ram enable comes up set
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         top_ff.sysctl    <= SYS_CONTROL_RESET;
         top_ff.rdata     <= '0;
         top_ff.st        <= ST_RUN;
         top_ff.nmi_prev  <= 1'b1;
         top_ff.nmi_req   <= 1'b0;
         top_ff.mask_p    <= 1'b0;
         top_ff.user_p    <= 1'b0;
         top_ff.sleep_p   <= 1'b0;
         top_ff.stby_p    <= 1'b0;
         top_ff.resume_p  <= 1'b0;
         top_ff.tmr_start <= 1'b0;
      end else begin
         top_ff <= nxt_top;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************

   // register port and event pulses
   assign o_rdata          = top_ff.rdata;
   assign o_nmi_request    = top_ff.nmi_req;
   assign o_set_mask_flag  = top_ff.mask_p;
   assign o_set_user_flag  = top_ff.user_p;
   assign o_user_flag_mode = top_ff.sysctl[USER_FLAG_EN_BIT];
   assign o_sleep_entry    = top_ff.sleep_p;
   assign o_standby_entry  = top_ff.stby_p;
   assign o_resume         = top_ff.resume_p;

   // mode dependent memory and bus setup
   assign o_mode_valid  = dec_valid;
   assign o_expanded    = dec_expanded;
   assign o_init_bus_16 = dec_init16;
   assign o_rom_enable  = dec_rom;
   assign o_space       = dec_space;
   assign o_ports_free  = dec_single;
   assign o_bus_16      = dec_expanded && (|i_area_width_control);

   // ram range goes external when disabled in expanded modes
   assign o_ram_external = i_ram_range_hit && dec_expanded
                           && !top_ff.sysctl[RAM_ENABLE_BIT];
   assign o_ram_internal = i_ram_range_hit && !o_ram_external;

   // external bus pins during standby
   assign o_in_standby = (top_ff.st == ST_STANDBY) || (top_ff.st == ST_SETTLE);
   assign o_addr_hiz   = o_in_standby && !top_ff.sysctl[STBY_KEEP_BIT];
   assign o_ctrl_hiz   = o_in_standby && !top_ff.sysctl[STBY_KEEP_BIT];
   assign o_addr_hold  = o_in_standby && top_ff.sysctl[STBY_KEEP_BIT];
   assign o_ctrl_high  = o_in_standby && top_ff.sysctl[STBY_KEEP_BIT];

endmodule : omsc_top

// ===== omsc_pkg.sv
package omsc_pkg;

   // ************************************************************
   // register map (low 20 address bits)
   // ************************************************************
   localparam int          ADDR_W            = 20;
   localparam int          DATA_W            = 8;
   localparam logic [19:0] MODE_STATUS_ADDR  = 20'h0_ee011;
   localparam logic [19:0] SYS_CONTROL_ADDR  = 20'h0_ee012;

   // ************************************************************
   // mode pin status layout
   // ************************************************************
   localparam logic [7:0]  MODE_STATUS_FIXED = 8'h00_c0; // bits 7:6 one
   localparam int          MODE_BITS_LSB     = 0;
   localparam int          MODE_BITS_W       = 3;

   // ************************************************************
   // system control layout and reset value
   // ************************************************************
   localparam logic [7:0]  SYS_CONTROL_RESET = 8'h00_09;
   localparam int          STANDBY_SEL_BIT   = 7;
   localparam int          SETTLE_MSB        = 6;
   localparam int          SETTLE_LSB        = 4;
   localparam int          USER_FLAG_EN_BIT  = 3;
   localparam int          NMI_EDGE_BIT      = 2;
   localparam int          STBY_KEEP_BIT     = 1;
   localparam int          RAM_ENABLE_BIT    = 0;

   // ************************************************************
   // settle waits in states; one state is one clock period
   // ************************************************************
   localparam int          CLK_PERIOD_NS     = 40;
   localparam int          STATE_PERIOD_NS   = 40;
   localparam int          CYC_PER_STATE     = STATE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          SETTLE_CNT_W      = 19;
   localparam int unsigned SETTLE_STATES_0   = 8192;
   localparam int unsigned SETTLE_STATES_1   = 16384;
   localparam int unsigned SETTLE_STATES_2   = 32768;
   localparam int unsigned SETTLE_STATES_3   = 65536;
   localparam int unsigned SETTLE_STATES_4   = 131072;
   localparam int unsigned SETTLE_STATES_5   = 262144;
   localparam int unsigned SETTLE_STATES_6   = 1024;

   // ************************************************************
   // address space sizes
   // ************************************************************
   localparam logic [1:0]  SPACE_NONE        = 2'h0;
   localparam logic [1:0]  SPACE_64K         = 2'h1;
   localparam logic [1:0]  SPACE_1M          = 2'h2;
   localparam logic [1:0]  SPACE_16M         = 2'h3;

   // power state of the core
   typedef enum logic [1:0] {
      ST_RUN,
      ST_SLEEP,
      ST_STANDBY,
      ST_SETTLE
   } omsc_state_e;

endpackage : omsc_pkg

// ===== omsc_mode_decode.sv
module omsc_mode_decode
   import omsc_pkg::*;
(
   input  wire logic [2:0] i_mode,         // mode pin levels
   output logic            o_valid,        // pattern is a mode 1..7
   output logic            o_expanded,     // modes 1..5
   output logic            o_single_chip,  // modes 6 and 7
   output logic            o_init_bus_16,  // initial width is 16 bits
   output logic            o_rom_enable,   // internal rom reachable
   output logic [1:0]      o_space         // address space size code
);

   // ************************************************************
   // decode of the strapped mode number
   // ************************************************************

   // mode number to space size
   always_comb begin
      o_valid       = (i_mode != 3'h0);
      o_expanded    = o_valid && (i_mode <= 3'h5);
      o_single_chip = (i_mode >= 3'h6);
      o_init_bus_16 = (i_mode == 3'h2) || (i_mode == 3'h4);
      o_rom_enable  = (i_mode >= 3'h5);
      unique case (i_mode)
         3'h1, 3'h2, 3'h7: o_space = SPACE_1M;
         3'h3, 3'h4, 3'h5: o_space = SPACE_16M;
         3'h6:             o_space = SPACE_64K;
         3'h0:             o_space = SPACE_NONE;
      endcase
   end

endmodule : omsc_mode_decode

// ===== omsc_settle_timer.sv
module omsc_settle_timer
   import omsc_pkg::*;
#(
   parameter int CNT_W = SETTLE_CNT_W
)
(
   input  wire logic             i_mclk,     // system clock
   input  wire logic             i_sys_rst,  // sync reset, high
   input  wire logic             i_start,    // load and run
   input  wire logic [CNT_W-1:0] i_count,    // wait in cycles, >= 1
   output logic                  o_busy,     // counting
   output logic                  o_done      // one-cycle pulse at end
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             busy;
      logic             done;
   } omsc_tmr_s;

   omsc_tmr_s tmr_ff;
   omsc_tmr_s nxt_tmr;

   // ************************************************************
   // down counter; done fires i_count + 1 cycles after start
   // ************************************************************

   // next state of the counter
   always_comb begin
      nxt_tmr      = tmr_ff;
      nxt_tmr.done = 1'b0;
      if (i_start) begin
         nxt_tmr.cnt  = i_count - CNT_W'(1);
         nxt_tmr.busy = 1'b1;
      end else if (tmr_ff.busy) begin
         if (tmr_ff.cnt == '0) begin
            nxt_tmr.busy = 1'b0;
            nxt_tmr.done = 1'b1;
         end else begin
            nxt_tmr.cnt = tmr_ff.cnt - CNT_W'(1);
         end
      end
   end

   // register the counter
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         tmr_ff <= '0;
      end else begin
         tmr_ff <= nxt_tmr;
      end
   end

   assign o_busy = tmr_ff.busy;
   assign o_done = tmr_ff.done;

endmodule : omsc_settle_timer

// ===== omsc_board.sv
module omsc_board (
   input  wire logic       i_mclk,        // system clock
   input  wire logic       i_sys_rst,     // device reset, high
   input  wire logic [2:0] i_mode_sel,    // wanted strap, 1..7
   output logic            o_mode_pin_2,  // strap pin 2
   output logic            o_mode_pin_1,  // strap pin 1
   output logic            o_mode_pin_0   // strap pin 0
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] strap_ff = 3'h7;

   // straps only move while the device is held in reset, never to 000
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst && i_mode_sel != 3'h0) begin
         strap_ff <= i_mode_sel;
      end
   end

   // pins hold the strap from one reset to the next
   assign {o_mode_pin_2, o_mode_pin_1, o_mode_pin_0} = strap_ff;
endmodule : omsc_board

// ===== omsc_top_chk.sv
module omsc_top_chk
   import omsc_pkg::*;
#(
   parameter int unsigned P_SETTLE_6 = SETTLE_STATES_6,
   parameter int          N_AREAS    = 8
)
(
   input wire logic               i_mclk,         // system clock
   input wire logic               i_sys_rst,      // sync reset, high
   input wire logic [ADDR_W-1:0]  i_addr,         // register address
   input wire logic [DATA_W-1:0]  i_wdata,        // write data
   input wire logic               i_wr,           // write strobe
   input wire logic               i_rd,           // read strobe
   input wire logic [DATA_W-1:0]  o_rdata,        // read data
   input wire logic               i_mode_pin_2,   // mode pin 2
   input wire logic               i_mode_pin_1,   // mode pin 1
   input wire logic               i_mode_pin_0,   // mode pin 0
   input wire logic [N_AREAS-1:0] i_area_width_control, // area widths
   input wire logic               o_expanded,     // external bus mode
   input wire logic               o_init_bus_16,  // initial width 16
   input wire logic               o_bus_16,       // current width 16
   input wire logic               o_rom_enable,   // rom reachable
   input wire logic [1:0]         o_space,        // space size code
   input wire logic               o_ports_free,   // ports general io
   input wire logic               i_ram_range_hit,// ram range access
   input wire logic               o_ram_external, // ram range to bus
   input wire logic               i_sleep_exec,   // sleep executed
   input wire logic               i_ext_irq,      // external interrupt
   input wire logic               i_exc_entry,    // exception entry
   input wire logic               i_nmi,          // nmi level
   input wire logic               o_nmi_request,  // nmi pulse
   input wire logic               o_set_mask_flag,// mask flag pulse
   input wire logic               o_set_user_flag,// second flag pulse
   input wire logic               o_sleep_entry,  // sleep pulse
   input wire logic               o_standby_entry,// standby pulse
   input wire logic               o_resume,       // resume pulse
   input wire logic               o_in_standby,   // in standby
   input wire logic               o_addr_hiz      // address bus off
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int W6 = P_SETTLE_6 + 3;

   logic [2:0] md;
   logic [7:0] ctl_ff;
   logic       stby_ff;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   // ************************************************************
   // shadow state
   // ************************************************************
   assign md = {i_mode_pin_2, i_mode_pin_1, i_mode_pin_0};

   // mirror of the control register and of standby awaiting wake-up
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ctl_ff  <= SYS_CONTROL_RESET;
         stby_ff <= 1'b0;
      end else begin
         if (i_wr && i_addr == SYS_CONTROL_ADDR) ctl_ff <= i_wdata;
         if (o_standby_entry) stby_ff <= 1'b1;
         else if (i_ext_irq) stby_ff <= 1'b0;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   status_read_a: assert property (i_rd && i_addr == MODE_STATUS_ADDR
      |=> o_rdata == {5'h18, $past(md)}) else $error("mode status read");
   ctl_read_a: assert property (i_rd && i_addr == SYS_CONTROL_ADDR
      |=> o_rdata == $past(ctl_ff)) else $error("control read");
   unmapped_zero_a: assert property (!(i_rd && (i_addr == MODE_STATUS_ADDR
      || i_addr == SYS_CONTROL_ADDR)) |=> o_rdata == 8'h00)
      else $error("read data not zero");
   space_map_a: assert property (o_space == ((md == 3'h6) ? 2'h1 :
      (md inside {3'h1, 3'h2, 3'h7}) ? 2'h2 : 2'h3)) else $error("space");
   rom_map_a: assert property (o_rom_enable == (md >= 3'h5)
      && o_expanded == (md <= 3'h5)) else $error("rom or expanded");
   bus_width_a: assert property (o_init_bus_16 == (md == 3'h2 || md == 3'h4)
      && o_bus_16 == (o_expanded && |i_area_width_control))
      else $error("bus width");
   ports_free_a: assert property (o_ports_free == (md >= 3'h6))
      else $error("ports free");
   ram_route_a: assert property (o_ram_external ==
      (i_ram_range_hit && o_expanded && !ctl_ff[0])) else $error("ram route");
   standby_pick_a: assert property (o_standby_entry
      |-> $past(i_sleep_exec) && $past(ctl_ff[7])) else $error("standby");
   sleep_pick_a: assert property (o_sleep_entry
      |-> $past(i_sleep_exec) && !$past(ctl_ff[7])) else $error("sleep");
   settle_wait_a: assert property (stby_ff && o_in_standby && i_ext_irq
      && ctl_ff[6:4] == 3'h6 |-> ##W6 o_resume) else $error("settle wait");
   nmi_edge_a: assert property ((ctl_ff[2] ? $rose(i_nmi) : $fell(i_nmi))
      |=> o_nmi_request) else $error("nmi edge");
   exc_flags_a: assert property (i_exc_entry |=> o_set_mask_flag
      && o_set_user_flag == !$past(ctl_ff[3])) else $error("exception flags");
   standby_bus_a: assert property (o_addr_hiz == (o_in_standby && !ctl_ff[1]))
      else $error("standby bus");
endmodule : omsc_top_chk

bind omsc_top omsc_top_chk #(.P_SETTLE_6(P_SETTLE_6), .N_AREAS(N_AREAS))
   u_chk (.*);

// ===== tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import omsc_pkg::*;

   localparam int unsigned P6 = 4;
   localparam logic [1:0]  SP [8] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3,
                                      2'h1, 2'h2};

   logic        i_mclk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic [19:0] i_addr = 20'h0_0000;
   logic [7:0]  i_wdata = 8'h00, i_area_width_control = 8'h00, o_rdata;
   logic [2:0]  mode_sel = 3'h1;
   logic        i_mode_pin_2, i_mode_pin_1, i_mode_pin_0, i_ram_range_hit = 0;
   logic        i_sleep_exec = 0, i_wake_irq = 0, i_ext_irq = 0;
   logic        i_exc_entry = 0, i_nmi = 1'b1;
   logic        o_mode_valid, o_expanded, o_init_bus_16, o_bus_16, o_rom_enable;
   logic [1:0]  o_space;
   logic        o_ports_free, o_ram_internal, o_ram_external, o_nmi_request;
   logic        o_set_mask_flag, o_set_user_flag, o_user_flag_mode;
   logic        o_sleep_entry, o_standby_entry, o_resume, o_in_standby;
   logic        o_addr_hiz, o_ctrl_hiz, o_addr_hold, o_ctrl_high;
   int          fails = 0, n_compared = 0;

   // 25 MHz system clock
   always #20 i_mclk = ~i_mclk;

   omsc_top #(.P_SETTLE_6(P6)) u_dut (.*);

   omsc_board u_board (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_mode_sel(mode_sel), .o_mode_pin_2(i_mode_pin_2),
      .o_mode_pin_1(i_mode_pin_1), .o_mode_pin_0(i_mode_pin_0));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input bit ok, input string msg);
      n_compared++;
      if (!ok) begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : check

   task automatic do_reset;
      i_sys_rst <= 1'b1;
      repeat (8) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
   endtask : do_reset

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [19:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 check(o_rdata === exp, "read data");
   endtask : rd

   // one-cycle core event: 0 sleep, 1 wake, 2 external irq, 3 exception
   task automatic pulse(input int k);
      @(posedge i_mclk);
      {i_sleep_exec, i_wake_irq, i_ext_irq, i_exc_entry} <= 4'h8 >> k;
      @(posedge i_mclk);
      {i_sleep_exec, i_wake_irq, i_ext_irq, i_exc_entry} <= 4'h0;
      #1;
   endtask : pulse

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // ************************************************************
   // scenarios
   // ************************************************************
   // every strap, with one area set to 16 bits in odd modes
   task automatic t_modes;
      for (int m = 1; m <= 7; m++) begin
         mode_sel <= 3'(m);
         i_area_width_control <= m[0] ? 8'h10 : 8'h00;
         do_reset();
         rd(MODE_STATUS_ADDR, 8'hc0 | 8'(m));
         check(o_space === SP[m], "space size");
         check(o_rom_enable === (m >= 5), "rom enable");
         check(o_init_bus_16 === (m == 2 || m == 4), "init width");
         check(o_bus_16 === (m <= 5 && m[0]), "bus width");
         check(o_ports_free === (m >= 6) && o_mode_valid === 1'b1, "ports");
      end
      wr(MODE_STATUS_ADDR, 8'hff);
      rd(MODE_STATUS_ADDR, 8'hc7);
   endtask : t_modes

   task automatic t_regs;
      mode_sel <= 3'h1;
      do_reset();
      rd(SYS_CONTROL_ADDR, 8'h09);
      wr(SYS_CONTROL_ADDR, 8'h76);
      rd(SYS_CONTROL_ADDR, 8'h76);
      wr(20'h0_ee013, 8'h00);
      rd(20'h0_ee013, 8'h00);
      i_ram_range_hit <= 1'b1;
      rd(SYS_CONTROL_ADDR, 8'h76);
      check(o_ram_external === 1'b1 && o_ram_internal === 1'b0, "ram off");
      do_reset();
      rd(SYS_CONTROL_ADDR, 8'h09);
      check(o_ram_internal === 1'b1 && o_ram_external === 1'b0, "ram on");
   endtask : t_regs

   // standby with the shortest settle code, bus pins off or kept
   task automatic t_standby(input logic [7:0] ctl);
      int n;
      wr(SYS_CONTROL_ADDR, ctl);
      pulse(0);
      check(o_standby_entry === 1'b1 && o_in_standby === 1'b1, "standby");
      check(o_addr_hiz === !ctl[1] && o_ctrl_hiz === !ctl[1], "hiz");
      check(o_addr_hold === ctl[1] && o_ctrl_high === ctl[1], "keep");
      pulse(2);
      n = 1;
      while (o_resume !== 1'b1 && n < 50) begin
         @(posedge i_mclk);
         #1 n++;
      end
      check(n == P6 + 3 && o_in_standby === 1'b0, "settle wait");
      rd(SYS_CONTROL_ADDR, ctl);
   endtask : t_standby

   task automatic t_sleep;
      wr(SYS_CONTROL_ADDR, 8'h09);
      pulse(0);
      check(o_sleep_entry === 1'b1 && o_standby_entry === 1'b0, "sleep");
      check(o_in_standby === 1'b0, "sleep not standby");
      pulse(1);
      check(o_resume === 1'b1 && o_in_standby === 1'b0, "wake");
   endtask : t_sleep

   task automatic t_nmi;
      @(posedge i_mclk);
      i_nmi <= 1'b0;
      @(posedge i_mclk);
      #1 check(o_nmi_request === 1'b1, "falling edge");
      wr(SYS_CONTROL_ADDR, 8'h0d);
      @(posedge i_mclk);
      i_nmi <= 1'b1;
      @(posedge i_mclk);
      #1 check(o_nmi_request === 1'b1, "rising edge");
      @(posedge i_mclk);
      i_nmi <= 1'b0;
      @(posedge i_mclk);
      #1 check(o_nmi_request === 1'b0, "wrong edge");
      @(posedge i_mclk);
      i_nmi <= 1'b1;
   endtask : t_nmi

   task automatic t_exc;
      wr(SYS_CONTROL_ADDR, 8'h09);
      pulse(3);
      check(o_set_mask_flag === 1'b1 && o_set_user_flag === 1'b0, "ue 1");
      check(o_user_flag_mode === 1'b1, "user mode");
      wr(SYS_CONTROL_ADDR, 8'h01);
      pulse(3);
      check(o_set_mask_flag === 1'b1 && o_set_user_flag === 1'b1, "ue 0");
      check(o_user_flag_mode === 1'b0, "mask mode");
   endtask : t_exc

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      t_modes();
      t_regs();
      t_standby(8'he9);
      t_standby(8'he3);
      t_sleep();
      t_nmi();
      t_exc();
      close_out();
   end
endmodule : tb
